// ### fbcr_config_bank.sv
// fuse backed configuration register bank with unlock protection
// Behaviour
// - audio bit 6 picks volume pin as potentiometer (0) or up/down buttons (1)
// - audio bit 5 sets line input single ended (0) or mono balanced (1)
// - audio bit 4 sets microphone input single ended (0) or mono balanced (1)
// - audio bit 3 sets headphone stage single ended (0) or mono balanced (1)
// - audio bits 2:0 attenuate monitor line 6 dB per step, 111 mutes
// - amp bits 7:6 select headphone source: mic, amp one, amp two, none
// - amp bits 5:2: 0000 inverting, else non-inverting gain in 0.75 dB steps
// - amp bit 1 enables second amp, bit 0 enables first amp
// - system bit 7 set locks all further fuse programming
// - system bit 6 is read-only test bit reading 1
// - system bits 5:4 select headphone source in monitor mode, same encoding
// - write-only system bits 3:2 set indicator sink current off, quarter, half, full
// - system bit 1 set disables microphone supply charge pump
// - system bit 0 set forces serial-controlled start-up only
// - fuse backed registers reset then load from their fuses
// - clock config bit 3 enables external fuse burn clock
// - fuse access bit 4 closes burn switch from left line pin to negative rail
// - fuse access bit 3 opens test window for registers 34h-35h and 14h-17h
// - fuse access bit 2 opens test window for registers 30h-33h and 10h-13h
// - fuse access bits 1:0 pick read, load, write or burn
`timescale 1ns/1ps
`default_nettype none
module fbcr_config_bank
(
	input wire logic clk,
	input wire logic reset,
	input wire logic bus_write,
	input wire logic [7:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	input wire logic [7:0] fuse_word,
	output logic [2:0] fuse_index,
	output logic fuse_ready,
	output fbcr_pkg::fbcr_audio_type audio_out,
	output fbcr_pkg::fbcr_amp_type amp_out,
	output fbcr_pkg::fbcr_system_type system_out,
	output fbcr_pkg::fbcr_access_type access_out,
	output logic external_burn_clock_enable,
	output logic fuse_program_allowed,
	output logic monitor_line_mute,
	output logic [5:0] monitor_line_atten_db,
	output logic second_amp_inverting
);
	fbcr_pkg::fbcr_write_type wr;
	fbcr_pkg::fbcr_audio_type audio_reg;
	fbcr_pkg::fbcr_amp_type amp_reg;
	fbcr_pkg::fbcr_system_type system_reg;
	fbcr_pkg::fbcr_access_type access_reg;
	logic [7:0] clock_reg;
	logic clock_unlock_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic allowed_reg;
	logic mute_reg;
	logic [5:0] atten_db_reg;
	logic inverting_reg;
	logic load_strobe;
	logic load_done;
	logic [2:0] load_index;
	logic fuse_unlocked;
	logic [7:0] load_word;
	logic [$bits(fbcr_pkg::fbcr_write_type)-1:0] bus_sync;

	// bus pins arrive from the serial front end in another timing domain
	fbcr_sync #(.WIDTH($bits(fbcr_pkg::fbcr_write_type))) u_bus_sync
	(
		.clk(clk),
		.reset(reset),
		.async_in({bus_write, bus_addr, bus_wdata}),
		.sync_out(bus_sync)
	);
	assign wr = bus_sync;

	fbcr_fuse_loader u_loader
	(
		.clk(clk),
		.reset(reset),
		.fuse_word(fuse_word),
		.fuse_index(load_index),
		.load_strobe(load_strobe),
		.load_done(load_done)
	);

	// the word is captured one cycle after its index was presented
	logic [2:0] load_index_reg;
	logic [7:0] load_word_reg;
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			load_index_reg <= fbcr_pkg::FUSE_AUDIO_IDX;
			load_word_reg <= 8'h00;
		end
		else
		begin
			load_index_reg <= load_index;
			load_word_reg <= fuse_word;
		end
	end
	assign load_word = load_word_reg;

	// a level write strobe held several cycles simply rewrites the same value
	logic write_hit;
	assign write_hit = wr.write_strobe & load_done;
	assign fuse_unlocked = (access_reg.fuse_mode == fbcr_pkg::FUSE_UNLOCK_MODE);

	always_ff @(posedge clk)
	begin
		if (reset)
			audio_reg <= fbcr_pkg::AUDIO_SETTINGS_RESET;
		else if (load_strobe && load_index_reg == fbcr_pkg::FUSE_AUDIO_IDX)
			audio_reg <= load_word;
		else if (write_hit && wr.addr == fbcr_pkg::AUDIO_SETTINGS_ADDR && fuse_unlocked)
			audio_reg <= wr.data;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			amp_reg <= fbcr_pkg::AMP_CONFIG_RESET;
		else if (load_strobe && load_index_reg == fbcr_pkg::FUSE_AMP_IDX)
			amp_reg <= load_word;
		else if (write_hit && wr.addr == fbcr_pkg::AMP_CONFIG_ADDR && fuse_unlocked)
			amp_reg <= wr.data;
	end

	// test bit is forced to one; nothing a fuse or the host writes can clear it
	always_ff @(posedge clk)
	begin
		if (reset)
			system_reg <= fbcr_pkg::SYSTEM_SETTINGS_RESET;
		else if (load_strobe && load_index_reg == fbcr_pkg::FUSE_SYSTEM_IDX)
			system_reg <= (load_word & fbcr_pkg::SYSTEM_WRITE_MASK) | fbcr_pkg::TEST_BIT_MASK;
		else if (write_hit && wr.addr == fbcr_pkg::SYSTEM_SETTINGS_ADDR && fuse_unlocked)
			system_reg <= (wr.data & fbcr_pkg::SYSTEM_WRITE_MASK) | fbcr_pkg::TEST_BIT_MASK;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			access_reg <= fbcr_pkg::FUSE_ACCESS_RESET;
		else if (load_strobe && load_index_reg == fbcr_pkg::FUSE_ACCESS_IDX)
			access_reg <= load_word & fbcr_pkg::FUSE_ACCESS_MASK;
		else if (write_hit && wr.addr == fbcr_pkg::FUSE_ACCESS_ADDR)
			access_reg <= wr.data & fbcr_pkg::FUSE_ACCESS_MASK;
	end

	// unlock for the clock register stays armed until the next other write
	always_ff @(posedge clk)
	begin
		if (reset)
			clock_unlock_reg <= 1'b0;
		else if (write_hit)
			clock_unlock_reg <= (wr.addr == fbcr_pkg::CLOCK_UNLOCK_ADDR) &&
				(wr.data == fbcr_pkg::CLOCK_UNLOCK_VALUE);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			clock_reg <= fbcr_pkg::CLOCK_CONFIG_RESET;
		else if (load_strobe && load_index_reg == fbcr_pkg::FUSE_CLOCK_IDX)
			clock_reg <= load_word & fbcr_pkg::CLOCK_CONFIG_MASK;
		else if (write_hit && wr.addr == fbcr_pkg::CLOCK_CONFIG_ADDR && clock_unlock_reg)
			clock_reg <= wr.data & fbcr_pkg::CLOCK_CONFIG_MASK;
	end

	// indicator current bits are write-only and read back as zero
	always_comb
	begin
		rdata_next = 8'h00;
		unique case (wr.addr)
			fbcr_pkg::AUDIO_SETTINGS_ADDR: rdata_next = audio_reg;
			fbcr_pkg::AMP_CONFIG_ADDR: rdata_next = amp_reg;
			fbcr_pkg::SYSTEM_SETTINGS_ADDR: rdata_next = system_reg & fbcr_pkg::SYSTEM_READ_MASK;
			fbcr_pkg::FUSE_ACCESS_ADDR: rdata_next = access_reg;
			fbcr_pkg::CLOCK_CONFIG_ADDR: rdata_next = clock_reg;
			default: rdata_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end

	// burning is blocked once the master lock is fused
	always_ff @(posedge clk)
	begin
		if (reset)
			allowed_reg <= 1'b0;
		else
			allowed_reg <= ~system_reg.main_fuse_lock &&
				(access_reg.fuse_mode == fbcr_pkg::FUSE_OP_WRITE ||
				access_reg.fuse_mode == fbcr_pkg::FUSE_OP_BURN);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			mute_reg <= 1'b0;
			atten_db_reg <= 6'h00;
			inverting_reg <= 1'b0;
		end
		else
		begin
			mute_reg <= (audio_reg.monitor_line_attenuation == fbcr_pkg::ATTEN_MUTE);
			atten_db_reg <= 6'(audio_reg.monitor_line_attenuation) * 6'(fbcr_pkg::ATTEN_STEP_DB);
			inverting_reg <= (amp_reg.second_amp_gain_mode == fbcr_pkg::AMP_INVERTING);
		end
	end

	assign bus_rdata = rdata_reg;
	assign fuse_index = load_index;
	assign fuse_ready = load_done;
	assign audio_out = audio_reg;
	assign amp_out = amp_reg;
	assign system_out = system_reg;
	assign access_out = access_reg;
	assign external_burn_clock_enable = clock_reg[fbcr_pkg::EXT_BURN_CLOCK_BIT];
	assign fuse_program_allowed = allowed_reg;
	assign monitor_line_mute = mute_reg;
	assign monitor_line_atten_db = atten_db_reg;
	assign second_amp_inverting = inverting_reg;

	sequence seq_locked_write(logic [7:0] a);
		write_hit && !load_strobe && wr.addr == a && !fuse_unlocked;
	endsequence

	sequence seq_unlocked_write(logic [7:0] a);
		write_hit && !load_strobe && wr.addr == a && fuse_unlocked;
	endsequence

	sequence seq_fuse_load(logic [2:0] idx);
		load_strobe && load_index_reg == idx;
	endsequence

	// protected registers keep their contents unless the unlock mode is in place
	AST_AMP_LOCKED: assert property (@(posedge clk) disable iff (reset)
		seq_locked_write(fbcr_pkg::AMP_CONFIG_ADDR) |=> $stable(amp_reg))
		else $error("amp register changed while locked");
	AST_SYSTEM_LOCKED: assert property (@(posedge clk) disable iff (reset)
		seq_locked_write(fbcr_pkg::SYSTEM_SETTINGS_ADDR) |=> $stable(system_reg))
		else $error("system register changed while locked");
	AST_AUDIO_LOCKED: assert property (@(posedge clk) disable iff (reset)
		seq_locked_write(fbcr_pkg::AUDIO_SETTINGS_ADDR) |=> $stable(audio_reg))
		else $error("audio register changed while locked");

	AST_AMP_WRITE: assert property (@(posedge clk) disable iff (reset)
		seq_unlocked_write(fbcr_pkg::AMP_CONFIG_ADDR) |=> amp_reg == $past(wr.data))
		else $error("unlocked amp write lost");
	AST_AUDIO_WRITE: assert property (@(posedge clk) disable iff (reset)
		seq_unlocked_write(fbcr_pkg::AUDIO_SETTINGS_ADDR) |=> audio_reg == $past(wr.data))
		else $error("unlocked audio write lost");
	AST_SYSTEM_WRITE: assert property (@(posedge clk) disable iff (reset)
		seq_unlocked_write(fbcr_pkg::SYSTEM_SETTINGS_ADDR)
		|=> system_reg == (($past(wr.data) & fbcr_pkg::SYSTEM_WRITE_MASK) | fbcr_pkg::TEST_BIT_MASK))
		else $error("unlocked system write lost");
	AST_ACCESS_WRITE: assert property (@(posedge clk) disable iff (reset)
		write_hit && !load_strobe && wr.addr == fbcr_pkg::FUSE_ACCESS_ADDR
		|=> access_reg == ($past(wr.data) & fbcr_pkg::FUSE_ACCESS_MASK))
		else $error("fuse access write lost");

	AST_CLOCK_GUARD: assert property (@(posedge clk) disable iff (reset)
		write_hit && wr.addr == fbcr_pkg::CLOCK_CONFIG_ADDR && !clock_unlock_reg && !load_strobe
		|=> $stable(clock_reg))
		else $error("clock register written without unlock");
	AST_CLOCK_WRITE: assert property (@(posedge clk) disable iff (reset)
		write_hit && !load_strobe && wr.addr == fbcr_pkg::CLOCK_CONFIG_ADDR && clock_unlock_reg
		|=> clock_reg == ($past(wr.data) & fbcr_pkg::CLOCK_CONFIG_MASK))
		else $error("unlocked clock write lost");
	AST_UNLOCK_ARMS: assert property (@(posedge clk) disable iff (reset)
		write_hit && wr.addr == fbcr_pkg::CLOCK_UNLOCK_ADDR && wr.data == fbcr_pkg::CLOCK_UNLOCK_VALUE
		|=> clock_unlock_reg)
		else $error("clock unlock not armed");
	AST_UNLOCK_CLEARS: assert property (@(posedge clk) disable iff (reset)
		write_hit && wr.addr != fbcr_pkg::CLOCK_UNLOCK_ADDR |=> !clock_unlock_reg)
		else $error("clock unlock survived another write");

	AST_LOAD_AUDIO: assert property (@(posedge clk) disable iff (reset)
		seq_fuse_load(fbcr_pkg::FUSE_AUDIO_IDX) |=> audio_reg == $past(load_word))
		else $error("audio fuse word not loaded");
	AST_LOAD_AMP: assert property (@(posedge clk) disable iff (reset)
		seq_fuse_load(fbcr_pkg::FUSE_AMP_IDX) |=> amp_reg == $past(load_word))
		else $error("amp fuse word not loaded");
	AST_LOAD_SYSTEM: assert property (@(posedge clk) disable iff (reset)
		seq_fuse_load(fbcr_pkg::FUSE_SYSTEM_IDX)
		|=> system_reg == (($past(load_word) & fbcr_pkg::SYSTEM_WRITE_MASK) | fbcr_pkg::TEST_BIT_MASK))
		else $error("system fuse word not loaded");
	AST_LOAD_CLOCK: assert property (@(posedge clk) disable iff (reset)
		seq_fuse_load(fbcr_pkg::FUSE_CLOCK_IDX) |=> clock_reg == ($past(load_word) & fbcr_pkg::CLOCK_CONFIG_MASK))
		else $error("clock fuse word not loaded");
	AST_LOAD_ACCESS: assert property (@(posedge clk) disable iff (reset)
		seq_fuse_load(fbcr_pkg::FUSE_ACCESS_IDX) |=> access_reg == ($past(load_word) & fbcr_pkg::FUSE_ACCESS_MASK))
		else $error("access fuse word not loaded");
	AST_READY_HOLDS: assert property (@(posedge clk) disable iff (reset)
		load_done |=> load_done)
		else $error("fuse ready dropped without reset");

	AST_TEST_BIT: assert property (@(posedge clk) disable iff (reset)
		system_reg.test_bit)
		else $error("test bit not one");
	AST_INDICATOR_LED_SINK_HIDDEN: assert property (@(posedge clk) disable iff (reset)
		wr.addr == fbcr_pkg::SYSTEM_SETTINGS_ADDR |=> bus_rdata[3:2] == 2'h0)
		else $error("indicator current readable");
	AST_READ_AUDIO: assert property (@(posedge clk) disable iff (reset)
		wr.addr == fbcr_pkg::AUDIO_SETTINGS_ADDR |=> bus_rdata == $past(audio_reg))
		else $error("audio read back wrong");
	AST_READ_AMP: assert property (@(posedge clk) disable iff (reset)
		wr.addr == fbcr_pkg::AMP_CONFIG_ADDR |=> bus_rdata == $past(amp_reg))
		else $error("amp read back wrong");
	AST_READ_ACCESS: assert property (@(posedge clk) disable iff (reset)
		wr.addr == fbcr_pkg::FUSE_ACCESS_ADDR |=> bus_rdata == $past(access_reg))
		else $error("fuse access read back wrong");
	AST_READ_CLOCK: assert property (@(posedge clk) disable iff (reset)
		wr.addr == fbcr_pkg::CLOCK_CONFIG_ADDR |=> bus_rdata == $past(clock_reg))
		else $error("clock read back wrong");

	AST_LOCK_BLOCKS: assert property (@(posedge clk) disable iff (reset)
		system_reg.main_fuse_lock |=> !fuse_program_allowed)
		else $error("fuse programming allowed under lock");
	AST_LOCK_FREE: assert property (@(posedge clk) disable iff (reset)
		!system_reg.main_fuse_lock && access_reg.fuse_mode == fbcr_pkg::FUSE_OP_BURN |=> fuse_program_allowed)
		else $error("burn refused without lock");
	AST_READ_MODE_BLOCKS: assert property (@(posedge clk) disable iff (reset)
		access_reg.fuse_mode == fbcr_pkg::FUSE_OP_READ |=> !fuse_program_allowed)
		else $error("programming allowed in read mode");

	AST_MUTE_CODE: assert property (@(posedge clk) disable iff (reset)
		audio_reg.monitor_line_attenuation == fbcr_pkg::ATTEN_MUTE ##1 $stable(audio_reg) |-> monitor_line_mute)
		else $error("mute code did not mute");
	AST_MUTE_CLEAR: assert property (@(posedge clk) disable iff (reset)
		audio_reg.monitor_line_attenuation != fbcr_pkg::ATTEN_MUTE |=> !monitor_line_mute)
		else $error("line muted without mute code");
	AST_INVERT: assert property (@(posedge clk) disable iff (reset)
		amp_reg.second_amp_gain_mode == fbcr_pkg::AMP_INVERTING |=> second_amp_inverting)
		else $error("inverting mode not flagged");
	AST_NONINVERT: assert property (@(posedge clk) disable iff (reset)
		amp_reg.second_amp_gain_mode != fbcr_pkg::AMP_INVERTING |=> !second_amp_inverting)
		else $error("gain code flagged as inverting");
endmodule
`default_nettype wire

// ### fbcr_config_bank_bench.sv
// self-checking bench for the fuse backed configuration bank
`timescale 1ns/1ps
`default_nettype none
module fbcr_config_bank_bench;
	logic clk;
	logic reset;
	logic bus_write;
	logic [7:0] bus_addr;
	logic [7:0] bus_wdata;
	logic [7:0] bus_rdata;
	logic [7:0] fuse_word;
	logic [2:0] fuse_index;
	logic fuse_ready;
	fbcr_pkg::fbcr_audio_type audio_out;
	fbcr_pkg::fbcr_amp_type amp_out;
	fbcr_pkg::fbcr_system_type system_out;
	fbcr_pkg::fbcr_access_type access_out;
	logic ext_clk;
	logic allowed;
	logic mute;
	logic [5:0] atten_db;
	logic inverting;
	logic [7:0] fuse_mem [5];
	logic [7:0] d;
	logic [7:0] rd;
	logic [3:0] g;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial fuse_mem = '{8'h5A, 8'h3C, 8'h05, 8'h08, 8'h11};
	assign fuse_word = (fuse_index <= fbcr_pkg::FUSE_LAST_IDX) ? fuse_mem[fuse_index] : 8'hA5;

	fbcr_host_model u_host (.clk(clk), .bus_rdata(bus_rdata), .bus_write(bus_write), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata));
	fbcr_config_bank u_dut (.clk(clk), .reset(reset), .bus_write(bus_write), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .fuse_word(fuse_word), .fuse_index(fuse_index),
		.fuse_ready(fuse_ready), .audio_out(audio_out), .amp_out(amp_out), .system_out(system_out),
		.access_out(access_out), .external_burn_clock_enable(ext_clk), .fuse_program_allowed(allowed),
		.monitor_line_mute(mute), .monitor_line_atten_db(atten_db), .second_amp_inverting(inverting));

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// reset, wait for the fuse walk, then compare every loaded register
	task automatic reset_and_load;
		reset = 1'b1;
		repeat (8) @(negedge clk);
		reset = 1'b0;
		for (int i = 0; i < 50 && fuse_ready !== 1'b1; i++)
			@(negedge clk);
		check("fuse_ready", 8'h01, {7'h00, fuse_ready});
		check("audio", 8'h5A, audio_out);
		check("atten", 8'h0C, {2'b00, atten_db});
		check("amp", 8'h3C, amp_out);
		check("system", 8'h45, system_out);
		check("ext_clk", 8'h01, {7'h00, ext_clk});
		check("access", 8'h11, access_out);
		check("allowed", 8'h00, {7'h00, allowed});
		u_host.read_reg(fbcr_pkg::SYSTEM_SETTINGS_ADDR, rd);
		check("sys read", 8'h41, rd);
		u_host.read_reg(fbcr_pkg::AUDIO_SETTINGS_ADDR, rd);
		check("audio read", 8'h5A, rd);
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failures++;
			wrap_up();
		end
	end

	initial
	begin
		reset = 1'b1;
		reset_and_load();
		u_host.write_reg(fbcr_pkg::AMP_CONFIG_ADDR, 8'hFF);
		check("amp locked", 8'h3C, amp_out);
		u_host.write_reg(fbcr_pkg::CLOCK_CONFIG_ADDR, 8'h00);
		check("clk locked", 8'h01, {7'h00, ext_clk});
		u_host.unlock_fuse();
		check("access", 8'h02, access_out);
		check("allowed", 8'h01, {7'h00, allowed});
		for (int i = 0; i < 4; i++)
		begin
			g = 4'(i * 5);
			d = {i[1:0], g, ~i[0], i[1]};
			u_host.write_reg(fbcr_pkg::AMP_CONFIG_ADDR, d);
			check("amp", d, amp_out);
			check("inverting", {7'h00, i == 0}, {7'h00, inverting});
			u_host.read_reg(fbcr_pkg::AMP_CONFIG_ADDR, rd);
			check("amp read", d, rd);
		end
		// volume pin stays enabled, so style bit is free to vary
		for (int c = 0; c < 8; c++)
		begin
			d = {1'b0, c[0], c[1], c[2], ~c[0], c[2:0]};
			u_host.write_reg(fbcr_pkg::AUDIO_SETTINGS_ADDR, d);
			check("audio", d, audio_out);
			check("mute", {7'h00, c == 7}, {7'h00, mute});
			if (c < 7)
				check("atten", 8'(c * 6), {2'b00, atten_db});
		end
		u_host.write_reg(fbcr_pkg::AUDIO_SETTINGS_ADDR, 8'hC0);
		check("audio", 8'hC0, audio_out);
		for (int i = 0; i < 4; i++)
		begin
			d = {2'b00, i[1:0], i[1:0], i[0], i[1]};
			u_host.write_reg(fbcr_pkg::SYSTEM_SETTINGS_ADDR, d);
			check("system", d | 8'h40, system_out);
			u_host.read_reg(fbcr_pkg::SYSTEM_SETTINGS_ADDR, rd);
			check("sys read", (d | 8'h40) & 8'hF3, rd);
		end
		for (int m = 0; m < 4; m++)
		begin
			d = {3'b000, m[0], m[1], ~m[0], m[1:0]};
			u_host.write_reg(fbcr_pkg::FUSE_ACCESS_ADDR, d);
			check("access", d, access_out);
			check("allowed", {7'h00, m[1]}, {7'h00, allowed});
		end
		u_host.unlock_fuse();
		u_host.write_reg(fbcr_pkg::SYSTEM_SETTINGS_ADDR, 8'h80);
		check("system", 8'hC0, system_out);
		check("allowed", 8'h00, {7'h00, allowed});
		u_host.unlock_clock();
		u_host.write_reg(fbcr_pkg::CLOCK_CONFIG_ADDR, 8'h00);
		check("ext_clk", 8'h00, {7'h00, ext_clk});
		u_host.unlock_clock();
		u_host.write_reg(fbcr_pkg::AUDIO_SETTINGS_ADDR, 8'h77);
		u_host.write_reg(fbcr_pkg::CLOCK_CONFIG_ADDR, 8'h08);
		check("ext_clk", 8'h00, {7'h00, ext_clk});
		u_host.unlock_clock();
		u_host.write_reg(fbcr_pkg::CLOCK_CONFIG_ADDR, 8'h08);
		check("ext_clk", 8'h01, {7'h00, ext_clk});
		u_host.write_reg(fbcr_pkg::FUSE_ACCESS_ADDR, 8'h01);
		u_host.write_reg(fbcr_pkg::AUDIO_SETTINGS_ADDR, 8'hFF);
		check("audio locked", 8'h77, audio_out);
		u_host.read_reg(8'h50, rd);
		check("unmapped", 8'h00, rd);
		reset_and_load();
		wrap_up();
	end
endmodule
`default_nettype wire

// ### fbcr_fuse_loader.sv
// walks the fuse words after reset and hands each to the register bank
`timescale 1ns/1ps
`default_nettype none
module fbcr_fuse_loader
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] fuse_word,
	output logic [2:0] fuse_index,
	output logic load_strobe,
	output logic load_done
);
	logic [2:0] index_reg;
	logic busy_reg;
	logic strobe_reg;
	logic done_reg;

	// fuse macro answers combinationally on the index, so one word per clock
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			index_reg <= fbcr_pkg::FUSE_AUDIO_IDX;
			busy_reg <= 1'b1;
		end
		else if (busy_reg)
		begin
			if (index_reg == fbcr_pkg::FUSE_LAST_IDX)
				busy_reg <= 1'b0;
			else
				index_reg <= index_reg + 3'h1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			strobe_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			strobe_reg <= busy_reg;
			done_reg <= ~busy_reg;
		end
	end

	assign fuse_index = index_reg;
	assign load_strobe = strobe_reg;
	assign load_done = done_reg;

	AST_LOADER_FINISHES: assert property (@(posedge clk) disable iff (reset)
		$fell(busy_reg) |-> ##1 done_reg) else $error("fuse load does not finish");
	// unused fuse_word here keeps the port width documented for the bank
	logic unused_fuse;
	assign unused_fuse = ^fuse_word;
endmodule
`default_nettype wire

// ### fbcr_host_model.sv
// host model that drives the pin level write and read interface of the bank
`timescale 1ns/1ps
`default_nettype none
module fbcr_host_model
(
	input wire logic clk,
	input wire logic [7:0] bus_rdata,
	output logic bus_write,
	output logic [7:0] bus_addr,
	output logic [7:0] bus_wdata
);
	initial
	begin
		bus_write = 1'b0;
		bus_addr = 8'h00;
		bus_wdata = 8'h00;
	end
	// exactly one cycle of write: a longer pulse would only rewrite the same value
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clk);
		bus_addr = addr;
		bus_wdata = data;
		@(negedge clk);
		bus_write = 1'b1;
		@(negedge clk);
		bus_write = 1'b0;
		repeat (3) @(negedge clk);
		// data lines are not held once the write has landed
		bus_wdata = ~data;
		@(negedge clk);
	endtask
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(negedge clk);
		bus_addr = addr;
		repeat (4) @(negedge clk);
		data = bus_rdata;
	endtask
	task automatic unlock_fuse;
		write_reg(fbcr_pkg::FUSE_ACCESS_ADDR, {6'h00, fbcr_pkg::FUSE_UNLOCK_MODE});
	endtask
	task automatic unlock_clock;
		write_reg(fbcr_pkg::CLOCK_UNLOCK_ADDR, fbcr_pkg::CLOCK_UNLOCK_VALUE);
	endtask
endmodule
`default_nettype wire

// ### fbcr_pkg.sv
// constants, field positions and carrier types of the fuse backed configuration bank
package fbcr_pkg;
	localparam logic [7:0] AUDIO_SETTINGS_ADDR = 8'h33;
	localparam logic [7:0] AMP_CONFIG_ADDR = 8'h34;
	localparam logic [7:0] SYSTEM_SETTINGS_ADDR = 8'h35;
	localparam logic [7:0] FUSE_ACCESS_ADDR = 8'h3F;
	localparam logic [7:0] CLOCK_UNLOCK_ADDR = 8'h20;
	localparam logic [7:0] CLOCK_CONFIG_ADDR = 8'h21;
	localparam logic [7:0] AUDIO_SETTINGS_RESET = 8'h00;
	localparam logic [7:0] AMP_CONFIG_RESET = 8'h00;
	localparam logic [7:0] SYSTEM_SETTINGS_RESET = 8'h40;
	localparam logic [7:0] FUSE_ACCESS_RESET = 8'h00;
	localparam logic [7:0] CLOCK_CONFIG_RESET = 8'h00;
	localparam logic [1:0] FUSE_UNLOCK_MODE = 2'h2;
	localparam logic [7:0] CLOCK_UNLOCK_VALUE = 8'h09;
	localparam logic [7:0] SYSTEM_WRITE_MASK = 8'hBF;
	localparam logic [7:0] SYSTEM_READ_MASK = 8'hF3;
	localparam logic [7:0] FUSE_ACCESS_MASK = 8'h1F;
	localparam logic [7:0] CLOCK_CONFIG_MASK = 8'h08;
	localparam logic [7:0] TEST_BIT_MASK = 8'h40;
	localparam int EXT_BURN_CLOCK_BIT = 3;
	localparam logic [2:0] ATTEN_STEP_DB = 3'h6;
	localparam logic [2:0] ATTEN_MUTE = 3'h7;
	localparam logic [3:0] AMP_INVERTING = 4'h0;
	localparam int FUSE_WORDS = 5;
	localparam logic [2:0] FUSE_AUDIO_IDX = 3'h0;
	localparam logic [2:0] FUSE_AMP_IDX = 3'h1;
	localparam logic [2:0] FUSE_SYSTEM_IDX = 3'h2;
	localparam logic [2:0] FUSE_CLOCK_IDX = 3'h3;
	localparam logic [2:0] FUSE_ACCESS_IDX = 3'h4;
	localparam logic [2:0] FUSE_LAST_IDX = 3'h4;

	typedef enum logic [1:0] {FUSE_OP_READ, FUSE_OP_LOAD, FUSE_OP_WRITE, FUSE_OP_BURN} fbcr_fuse_op_type;
	typedef enum logic [1:0] {SRC_MIC, SRC_FIRST_AMP, SRC_SECOND_AMP, SRC_NONE} fbcr_source_type;

	typedef struct packed {
		logic volume_input_disable;
		logic volume_input_style;
		logic line_input_topology;
		logic mic_input_topology;
		logic headphone_topology;
		logic [2:0] monitor_line_attenuation;
	} fbcr_audio_type;

	typedef struct packed {
		fbcr_source_type headphone_source_select;
		logic [3:0] second_amp_gain_mode;
		logic second_amp_enable;
		logic first_amp_enable;
	} fbcr_amp_type;

	typedef struct packed {
		logic main_fuse_lock;
		logic test_bit;
		fbcr_source_type monitor_headphone_source;
		logic [1:0] indicator_current_level;
		logic mic_supply_pump_disable;
		logic serial_only_startup;
	} fbcr_system_type;

	typedef struct packed {
		logic [2:0] unused_high;
		logic burn_switch_enable;
		logic upper_test_window_enable;
		logic lower_test_window_enable;
		fbcr_fuse_op_type fuse_mode;
	} fbcr_access_type;

	typedef struct packed {
		logic write_strobe;
		logic [7:0] addr;
		logic [7:0] data;
	} fbcr_write_type;
endpackage

// ### fbcr_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module fbcr_sync
#(
	parameter int WIDTH = 1
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] first_reg;
	logic [WIDTH-1:0] second_reg;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			first_reg <= '0;
			second_reg <= '0;
		end
		else
		begin
			first_reg <= async_in;
			second_reg <= first_reg;
		end
	end

	assign sync_out = second_reg;
endmodule
`default_nettype wire
